// ===== ulrx_defines.svh
// constants for the receive-command status byte generator
`ifndef ULRX_DEFINES_SVH
`define ULRX_DEFINES_SVH

// ------------------------------------------------------------
// status byte field positions
// ------------------------------------------------------------
`define ULRX_LS_LSB      0
`define ULRX_VBUS_LSB    2
`define ULRX_RXEV_LSB    4
`define ULRX_ID_BIT      6
`define ULRX_ALT_BIT     7

// ------------------------------------------------------------
// field encodings
// ------------------------------------------------------------
`define ULRX_VBUS_LOW    2'h0
`define ULRX_VBUS_END    2'h1
`define ULRX_VBUS_SESS   2'h2
`define ULRX_VBUS_VALID  2'h3
`define ULRX_RXEV_NONE   2'h0
`define ULRX_RXEV_ACT    2'h1
`define ULRX_RXEV_ERR    2'h3
`define ULRX_RXEV_DISC   2'h2
`define ULRX_LS_SQ_ON    2'h0
`define ULRX_LS_SQ_OFF   2'h1

// ------------------------------------------------------------
// bus values, event mask and reset values
// ------------------------------------------------------------
`define ULRX_IDLE_CMD    8'h00
`define ULRX_EVT_MASK    8'hcf
`define ULRX_PEND_RST    1'b1
`define ULRX_SEEN_RST    8'h00
`define ULRX_BUF_DEPTH   2

`endif

// ===== ulrx_pkg.sv
// types shared by the status byte generator
package ulrx_pkg;

    // sampled device status feeding the status byte
    typedef struct packed {
        logic dp_se;      // positive line single-ended receiver
        logic dm_se;      // negative line single-ended receiver
        logic hs_mode;    // high-speed operation
        logic squelch;    // high-speed squelch detected
        logic sess_end;   // below session end
        logic sess_vld;   // session valid comparator
        logic vbus_vld;   // vbus valid comparator
        logic id_pin;     // id pin level
        logic rx_active;  // receive in progress
        logic rx_error;   // receive error
        logic host_disc;  // host disconnect detected
        logic alt_int;    // any unmasked carkit latch bit
    } ulrx_status_t;

    // registered drive of the ulpi side
    typedef struct packed {
        logic       dir;  // bus direction, high = device owns
        logic       nxt;  // next / receive data marker
        logic       oe;   // data bus output enable
        logic [7:0] data; // data bus out
    } ulrx_ulpi_out_t;

    typedef enum logic [6:0] {
        S_STARTUP = 7'h01,
        S_IDLE    = 7'h02,
        S_TA_CMD  = 7'h04,
        S_TA_RX   = 7'h08,
        S_CMD     = 7'h10,
        S_RX      = 7'h20,
        S_TA_OFF  = 7'h40
    } ulrx_state_t;

endpackage : ulrx_pkg

// ===== ulrx_status_enc.sv
// status byte encoder
`timescale 1ns/1ps
`include "ulrx_defines.svh"

module ulrx_status_enc (
    input  wire ulrx_pkg::ulrx_status_t stat,      // sampled status
    output logic [7:0]                  stat_byte  // encoded byte
);

    logic [1:0] ls;
    logic [1:0] vb;
    logic [1:0] rx;

    always_comb
    begin
        if (stat.hs_mode)
            ls = stat.squelch ? `ULRX_LS_SQ_ON : `ULRX_LS_SQ_OFF;
        else
            ls = {stat.dm_se, stat.dp_se};
        if (stat.vbus_vld)
            vb = `ULRX_VBUS_VALID;
        else if (stat.sess_vld)
            vb = `ULRX_VBUS_SESS;
        else if (stat.sess_end)
            vb = `ULRX_VBUS_LOW;
        else
            vb = `ULRX_VBUS_END;
        if (stat.host_disc)
            rx = `ULRX_RXEV_DISC;
        else if (stat.rx_active)
            rx = stat.rx_error ? `ULRX_RXEV_ERR : `ULRX_RXEV_ACT;
        else
            rx = `ULRX_RXEV_NONE;
        stat_byte = 8'h00;
        stat_byte[`ULRX_LS_LSB +: 2]   = ls;
        stat_byte[`ULRX_VBUS_LSB +: 2] = vb;
        stat_byte[`ULRX_RXEV_LSB +: 2] = rx;
        stat_byte[`ULRX_ID_BIT]        = stat.id_pin;
        stat_byte[`ULRX_ALT_BIT]       = stat.alt_int;
    end

endmodule : ulrx_status_enc

// ===== ulrx_rx_buf.sv
// two-entry receive data buffer
`timescale 1ns/1ps
`include "ulrx_defines.svh"

module ulrx_rx_buf (
    input  wire logic       clk_sys,   // system clock
    input  wire logic       rst,       // sync reset, active high
    input  wire logic       in_valid,  // write side valid
    output logic            in_ready,  // write side ready
    input  wire logic [7:0] in_data,   // write data
    output logic            out_valid, // read side valid
    input  wire logic       out_ready, // read side ready
    output logic [7:0]      out_data   // read data
);

    logic [7:0] mem [`ULRX_BUF_DEPTH];
    logic [7:0] next_mem [`ULRX_BUF_DEPTH];
    logic       wr_idx;
    logic       rd_idx;
    logic [1:0] count;
    logic       next_wr_idx;
    logic       next_rd_idx;
    logic [1:0] next_count;
    logic       push;
    logic       pop;

    assign in_ready  = (count != 2'(`ULRX_BUF_DEPTH));
    assign out_valid = (count != 2'h0);
    assign out_data  = mem[rd_idx];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb
    begin
        next_mem    = mem;
        next_wr_idx = wr_idx;
        next_rd_idx = rd_idx;
        next_count  = count;
        if (push)
        begin
            next_mem[wr_idx] = in_data;
            next_wr_idx      = ~wr_idx;
        end
        if (pop)
            next_rd_idx = ~rd_idx;
        if (push & ~pop)
            next_count = count + 2'h1;
        else if (pop & ~push)
            next_count = count - 2'h1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wr_idx <= 1'b0;
            rd_idx <= 1'b0;
            count  <= 2'h0;
            mem[0] <= 8'h00;
            mem[1] <= 8'h00;
        end
        else
        begin
            wr_idx <= next_wr_idx;
            rd_idx <= next_rd_idx;
            count  <= next_count;
            mem    <= next_mem;
        end
    end

endmodule : ulrx_rx_buf

// ===== ulrx_rx_cmd_gen.sv
// receive-command status byte generator, device side of ulpi
`timescale 1ns/1ps
`include "ulrx_defines.svh"

module ulrx_rx_cmd_gen (
    input  wire logic                   clk_sys,     // ulpi-side clock
    input  wire logic                   rst,         // sync reset, high
    // ulpi pins
    output logic                        ulpi_dir,    // bus owned by device
    output logic                        ulpi_nxt,    // next / rx data
    input  wire logic                   ulpi_stp,    // stop from link
    input  wire logic [7:0]             ulpi_data_i, // data bus in
    output logic [7:0]                  ulpi_data_o, // data bus out
    output logic                        ulpi_data_oe,// data bus drive
    // device state
    input  wire ulrx_pkg::ulrx_status_t status,      // live status
    input  wire logic                   sync_mode,   // synchronous mode
    input  wire logic                   pll_ready,   // start-up done
    input  wire logic                   async_exit,  // left async mode
    input  wire logic                   tx_active,   // link transmit
    input  wire logic                   tx_hs,       // transmit is hs
    // received packet bytes
    input  wire logic                   rx_valid,    // rx byte valid
    output logic                        rx_ready,    // rx byte taken
    input  wire logic [7:0]             rx_data,     // rx byte
    // observation
    output logic                        cmd_pending  // status byte owed
);

    // ------------------------------------------------------------
    // status encoding and receive buffer
    // ------------------------------------------------------------
    logic [7:0] stat_byte;
    logic       buf_valid;
    logic       buf_pop;
    logic [7:0] buf_data;

    ulrx_status_enc u_enc (
        .stat      (status),
        .stat_byte (stat_byte)
    );

    ulrx_rx_buf u_buf (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .in_data   (rx_data),
        .out_valid (buf_valid),
        .out_ready (buf_pop),
        .out_data  (buf_data)
    );

    // ------------------------------------------------------------
    // event detection and send permission
    // ------------------------------------------------------------
    ulrx_pkg::ulrx_state_t    state;
    ulrx_pkg::ulrx_state_t    next_state;
    ulrx_pkg::ulrx_ulpi_out_t drv;
    ulrx_pkg::ulrx_ulpi_out_t next_drv;
    logic                     pend;
    logic                     next_pend;
    logic [7:0]               seen;
    logic [7:0]               next_seen;
    logic                     evt;
    logic                     taken;
    logic                     hold;
    logic                     may_send;
    logic                     rx_go;
    logic                     link_idle;

    // line state, vbus, id and alt-int bits are watched for change
    assign evt = ((stat_byte & `ULRX_EVT_MASK) != seen);

    // fs transmit: release after stp; hs transmit: blocked to the end
    assign hold = tx_active & (tx_hs | ~ulpi_stp);

    assign link_idle = ~ulpi_stp & (ulpi_data_i == `ULRX_IDLE_CMD);

    assign may_send = sync_mode & pend & ~hold
                    & (tx_active ? ulpi_stp : link_idle);

    assign rx_go = sync_mode & status.rx_active & ~tx_active;

    assign ulpi_dir     = drv.dir;
    assign ulpi_nxt     = drv.nxt;
    assign ulpi_data_oe = drv.oe;
    assign ulpi_data_o  = drv.data;
    assign cmd_pending  = pend;

    // ------------------------------------------------------------
    // bus protocol state machine
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_drv   = drv;
        taken      = 1'b0;
        buf_pop    = 1'b0;
        case (state)
            ulrx_pkg::S_STARTUP:
            begin
                // bus held until the clock is up, then released
                if (pll_ready)
                begin
                    next_state = ulrx_pkg::S_TA_OFF;
                    next_drv   = '0;
                end
                else
                begin
                    next_drv     = '0;
                    next_drv.dir = 1'b1;
                end
            end
            ulrx_pkg::S_IDLE:
            begin
                next_drv = '0;
                if (rx_go)
                begin
                    next_state   = ulrx_pkg::S_TA_RX;
                    next_drv.dir = 1'b1;
                    next_drv.nxt = 1'b1;
                end
                else if (may_send)
                begin
                    next_state   = ulrx_pkg::S_TA_CMD;
                    next_drv.dir = 1'b1;
                end
            end
            ulrx_pkg::S_TA_CMD:
            begin
                // turnaround done; status sampled as it goes out
                next_state    = ulrx_pkg::S_CMD;
                next_drv.dir  = 1'b1;
                next_drv.nxt  = 1'b0;
                next_drv.oe   = 1'b1;
                next_drv.data = stat_byte;
                taken         = 1'b1;
            end
            ulrx_pkg::S_TA_RX,
            ulrx_pkg::S_RX:
            begin
                next_drv.dir = 1'b1;
                next_drv.oe  = 1'b1;
                if (buf_valid)
                begin
                    next_state    = ulrx_pkg::S_RX;
                    next_drv.nxt  = 1'b1;
                    next_drv.data = buf_data;
                    buf_pop       = 1'b1;
                end
                else if (status.rx_active)
                begin
                    next_state    = ulrx_pkg::S_RX;
                    next_drv.nxt  = 1'b0;
                    next_drv.data = stat_byte;
                    taken         = 1'b1;
                end
                else
                begin
                    next_state = ulrx_pkg::S_TA_OFF;
                    next_drv   = '0;
                end
            end
            ulrx_pkg::S_CMD:
            begin
                if (rx_go)
                begin
                    next_state    = ulrx_pkg::S_RX;
                    next_drv.nxt  = buf_valid;
                    next_drv.data = buf_valid ? buf_data : stat_byte;
                    buf_pop       = buf_valid;
                    taken         = ~buf_valid;
                end
                else if (pend)
                begin
                    // back to back status while bus still held
                    next_state    = ulrx_pkg::S_CMD;
                    next_drv.nxt  = 1'b0;
                    next_drv.data = stat_byte;
                    taken         = 1'b1;
                end
                else
                begin
                    next_state = ulrx_pkg::S_TA_OFF;
                    next_drv   = '0;
                end
            end
            ulrx_pkg::S_TA_OFF:
            begin
                // data in is unknown this cycle and is not looked at
                next_state = ulrx_pkg::S_IDLE;
                next_drv   = '0;
            end
            default:
            begin
                next_state = ulrx_pkg::S_IDLE;
                next_drv   = '0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // pending status request
    // ------------------------------------------------------------
    always_comb
    begin
        next_seen = stat_byte & `ULRX_EVT_MASK;
        // a new event wins over the clear by a byte going out
        next_pend = evt | (pend & ~taken);
        if (async_exit & ~ulpi_stp & ~drv.dir)
            next_pend = 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state <= ulrx_pkg::S_STARTUP;
            drv   <= '0;
            pend  <= `ULRX_PEND_RST;
            seen  <= `ULRX_SEEN_RST;
        end
        else
        begin
            state <= next_state;
            drv   <= next_drv;
            pend  <= next_pend;
            seen  <= next_seen;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    turn_on_gap_a: assert property (
        $rose(ulpi_dir) |-> !ulpi_data_oe)
        else $error("data driven in dir rise turnaround");

    turn_off_gap_a: assert property (
        $fell(ulpi_dir) |-> !ulpi_data_oe ##1 !ulpi_data_oe)
        else $error("data driven after dir fall");

    cmd_after_ta_a: assert property (
        ($rose(ulpi_dir) && !ulpi_nxt && state == ulrx_pkg::S_TA_CMD)
        |=> ulpi_data_oe && !ulpi_nxt && ulpi_dir)
        else $error("status byte not driven after turnaround");

    rx_start_a: assert property (
        ($rose(ulpi_dir) && ulpi_nxt) |-> $past(status.rx_active))
        else $error("dir with nxt without receive");

    hs_hold_a: assert property (
        (tx_active && tx_hs && state == ulrx_pkg::S_IDLE)
        |=> !ulpi_dir)
        else $error("status sent during hs transmit");

    send_on_pend_a: assert property (
        (state == ulrx_pkg::S_IDLE && may_send && !rx_go)
        |=> ulpi_dir && !ulpi_nxt ##1 ulpi_data_oe)
        else $error("idle bus with pending status not taken");

    pend_on_evt_a: assert property (
        evt |=> pend)
        else $error("status change not scheduled");

    status_sample_a: assert property (
        (ulpi_data_oe && !ulpi_nxt) |-> ulpi_data_o == $past(stat_byte))
        else $error("status byte not sampled at send");

    vbus_enc_a: assert property (
        (!status.vbus_vld && !status.sess_vld && status.sess_end)
        |-> stat_byte[`ULRX_VBUS_LSB +: 2] == `ULRX_VBUS_LOW)
        else $error("vbus level misencoded");

    rx_disc_a: assert property (
        status.host_disc
        |-> stat_byte[`ULRX_RXEV_LSB +: 2] == `ULRX_RXEV_DISC)
        else $error("host disconnect misencoded");

    startup_rel_a: assert property (
        (state == ulrx_pkg::S_STARTUP && !pll_ready) |=> ulpi_dir)
        else $error("bus released before start-up done");

    b2b_cmd_c: cover property (
        state == ulrx_pkg::S_CMD ##1 state == ulrx_pkg::S_CMD);

    rx_data_c: cover property (
        ulpi_dir && ulpi_nxt && ulpi_data_oe ##1
        ulpi_dir && !ulpi_nxt && ulpi_data_oe);

    startup_c: cover property (
        state == ulrx_pkg::S_STARTUP ##1 state == ulrx_pkg::S_TA_OFF);

    fs_tx_stp_c: cover property (
        tx_active && !tx_hs && ulpi_stp && pend ##1 $rose(ulpi_dir));

endmodule : ulrx_rx_cmd_gen

// ===== ulrx_link_model.sv
// link controller model on the far side of the ulpi bus
`timescale 1ns/1ps

module ulrx_link_model (
    input  wire logic       clk_sys,      // ulpi clock
    input  wire logic       rst,          // sync reset, high
    input  wire logic       ulpi_dir,     // device owns bus
    input  wire logic       ulpi_nxt,     // rx data marker
    input  wire logic [7:0] ulpi_data_o,  // device drive
    input  wire logic       ulpi_data_oe, // device drive enable
    input  wire logic       stp_cmd,      // stop request from bench
    output logic            ulpi_stp,     // stop to device
    output logic [7:0]      ulpi_data_i,  // bus level seen by device
    output logic [7:0]      last_cmd,     // last status byte taken
    output logic [15:0]     cmd_cnt,      // status bytes taken
    output logic [15:0]     rx_cnt,       // rx bytes taken
    output logic [7:0]      last_run,     // cycles of last dir high run
    output logic            start_nxt,    // nxt in first dir cycle
    output logic            ta_err        // bus driven in turnaround
);
    logic       dir_q;
    logic [7:0] run;
    logic [7:0] float_q;
    logic [7:0] rx_log [0:7];

    // ------------------------------------------------------------
    // bus: link drives idle only after a full turnaround
    // ------------------------------------------------------------
    assign ulpi_stp    = stp_cmd;
    assign ulpi_data_i = ulpi_data_oe ? ulpi_data_o :
                         (!ulpi_dir && !dir_q) ? 8'h00 : float_q;

    // ------------------------------------------------------------
    // capture of what the device hands over
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            dir_q     <= 1'b0;
            run       <= 8'h00;
            float_q   <= 8'h5a;
            last_cmd  <= 8'h00;
            cmd_cnt   <= 16'h0000;
            rx_cnt    <= 16'h0000;
            last_run  <= 8'h00;
            start_nxt <= 1'b0;
            ta_err    <= 1'b0;
        end
        else
        begin
            dir_q   <= ulpi_dir;
            float_q <= ~float_q;
            run     <= ulpi_dir ? run + 8'h01 : 8'h00;
            if (!ulpi_dir && dir_q)
                last_run <= run;
            if (ulpi_dir && !dir_q)
                start_nxt <= ulpi_nxt;
            if ((ulpi_dir != dir_q) && ulpi_data_oe)
                ta_err <= 1'b1;
            if (ulpi_dir && ulpi_data_oe && !ulpi_nxt)
            begin
                last_cmd <= ulpi_data_o;
                cmd_cnt  <= cmd_cnt + 16'h0001;
            end
            if (ulpi_dir && ulpi_data_oe && ulpi_nxt)
            begin
                rx_log[rx_cnt[2:0]] <= ulpi_data_o;
                rx_cnt              <= rx_cnt + 16'h0001;
            end
        end
    end
endmodule : ulrx_link_model

// ===== ulpi_rx_status_command_gen_tb_top.sv
// testbench for the receive-command status byte generator
`timescale 1ns/1ps

module ulpi_rx_status_command_gen_tb_top;
    localparam logic [11:0] vtab = 12'h813;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        sync_mode = 1'b1;
    logic        pll_ready = 1'b0;
    logic        async_exit = 1'b0;
    logic        tx_active = 1'b0;
    logic        tx_hs = 1'b0;
    logic        rx_valid = 1'b0;
    logic        stp_cmd = 1'b0;
    logic [7:0]  rx_data = 8'h00;
    logic        dir, nxt, stp, oe, pend, rx_ready, start_nxt, ta_err;
    logic [7:0]  data_i, data_o, last_cmd, last_run;
    logic [15:0] cmd_cnt, rx_cnt, c0;
    int          mismatches = 0;
    int          comparisons = 0;
    ulrx_pkg::ulrx_status_t st, cur;

    always #2 clk_sys = ~clk_sys;

    ulrx_rx_cmd_gen dut_u (.clk_sys(clk_sys), .rst(rst), .ulpi_dir(dir),
        .ulpi_nxt(nxt), .ulpi_stp(stp), .ulpi_data_i(data_i),
        .ulpi_data_o(data_o), .ulpi_data_oe(oe), .status(st),
        .sync_mode(sync_mode), .pll_ready(pll_ready),
        .async_exit(async_exit), .tx_active(tx_active), .tx_hs(tx_hs),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
        .cmd_pending(pend));

    ulrx_link_model link_u (.clk_sys(clk_sys), .rst(rst), .ulpi_dir(dir),
        .ulpi_nxt(nxt), .ulpi_data_o(data_o), .ulpi_data_oe(oe),
        .stp_cmd(stp_cmd), .ulpi_stp(stp), .ulpi_data_i(data_i),
        .last_cmd(last_cmd), .cmd_cnt(cmd_cnt), .rx_cnt(rx_cnt),
        .last_run(last_run), .start_nxt(start_nxt), .ta_err(ta_err));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] enc(input ulrx_pkg::ulrx_status_t s);
        logic [1:0] ls, vb, ev;
        ls = s.hs_mode ? {1'b0, ~s.squelch} : {s.dm_se, s.dp_se};
        vb = s.vbus_vld ? 2'h3 : s.sess_vld ? 2'h2 : s.sess_end ? 2'h0 : 2'h1;
        ev = s.host_disc ? 2'h2 : {s.rx_active & s.rx_error, s.rx_active};
        return {s.alt_int, s.id_pin, ev, vb, ls};
    endfunction : enc

    task automatic results;
        if (mismatches == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic put;
        @(posedge clk_sys);
        st <= cur;
    endtask : put

    task automatic wait_idle;
        int q;
        q = 0;
        repeat (4) @(posedge clk_sys);
        for (int i = 0; i < 400 && q < 3; i++)
        begin
            @(negedge clk_sys);
            q = (!dir && !pend) ? q + 1 : 0;
        end
        if (q < 3)
        begin
            mismatches++;
            results();
        end
    endtask : wait_idle

    task automatic expect_cmd(input string name, input int n);
        wait_idle();
        check({name, " count"}, cmd_cnt - c0, 16'(n));
        check(name, {8'h00, last_cmd}, {8'h00, enc(cur)});
    endtask : expect_cmd

    task automatic one(input string name);
        c0 = cmd_cnt;
        put();
        expect_cmd(name, 1);
    endtask : one

    task automatic held(input string name);
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        check(name, cmd_cnt - c0, 16'h0000);
        check({name, " pend"}, 16'(pend), 16'h0001);
    endtask : held

    task automatic push(input logic [7:0] b);
        int i;
        rx_valid <= 1'b1;
        rx_data  <= b;
        i = 0;
        @(negedge clk_sys);
        while (!rx_ready && i < 50)
        begin
            @(negedge clk_sys);
            i++;
        end
        if (!rx_ready)
        begin
            mismatches++;
            results();
        end
        @(posedge clk_sys);
    endtask : push

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial
    begin
        cur = '0;
        cur.dp_se = 1'b1;
        cur.squelch = 1'b1;
        cur.sess_vld = 1'b1;
        cur.vbus_vld = 1'b1;
        cur.id_pin = 1'b1;
        st = cur;
        c0 = 16'h0000;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        check("reset drive", {oe, dir, pend}, 16'h0001);
        @(posedge clk_sys);
        rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        check("startup hold", 16'(dir), 16'h0001);
        @(posedge clk_sys);
        pll_ready <= 1'b1;
        expect_cmd("startup", 1);
        for (int k = 0; k < 4; k++)
        begin
            {cur.dm_se, cur.dp_se} = k[1:0];
            one("fs line state");
            check("dir run", {8'h00, last_run}, 16'h0002);
            check("status start", 16'(start_nxt), 16'h0000);
        end
        cur.hs_mode = 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            cur.squelch = k[0];
            one("hs line state");
        end
        cur.hs_mode = 1'b0;
        cur.dm_se = 1'b0;
        cur.dp_se = 1'b1;
        one("back to fs");
        for (int k = 0; k < 4; k++)
        begin
            {cur.sess_end, cur.sess_vld, cur.vbus_vld} = vtab[11 - 3 * k -: 3];
            one("vbus level");
        end
        cur.id_pin = 1'b0;
        one("id pin");
        cur.alt_int = 1'b1;
        one("alt int");
        check("alt flag", 16'(last_cmd[7]), 16'h0001);
        cur.alt_int = 1'b0;
        one("alt int clear");
        c0 = cmd_cnt;
        sync_mode <= 1'b0;
        cur.id_pin = 1'b1;
        put();
        held("async mode");
        sync_mode <= 1'b1;
        expect_cmd("sync again", 1);
        c0 = cmd_cnt;
        @(posedge clk_sys);
        tx_active <= 1'b1;
        tx_hs <= 1'b1;
        stp_cmd <= 1'b1;
        cur.dp_se = 1'b0;
        put();
        held("hs transmit");
        cur.dm_se = 1'b1;
        put();
        held("hs transmit late");
        tx_active <= 1'b0;
        tx_hs <= 1'b0;
        stp_cmd <= 1'b0;
        expect_cmd("after hs transmit", 1);
        c0 = cmd_cnt;
        tx_active <= 1'b1;
        cur.dp_se = 1'b1;
        put();
        held("fs transmit");
        stp_cmd <= 1'b1;
        expect_cmd("fs transmit stop", 1);
        stp_cmd <= 1'b0;
        tx_active <= 1'b0;
        c0 = cmd_cnt;
        @(posedge clk_sys);
        async_exit <= 1'b1;
        @(posedge clk_sys);
        async_exit <= 1'b0;
        expect_cmd("async exit", 1);
        c0 = cmd_cnt;
        cur.dp_se = 1'b0;
        put();
        repeat (2) @(posedge clk_sys);
        cur.id_pin = 1'b0;
        st <= cur;
        expect_cmd("back to back", 2);
        check("b2b run", {8'h00, last_run}, 16'h0003);
        @(posedge clk_sys);
        push(8'h3c);
        push(8'hc3);
        rx_valid <= 1'b0;
        @(negedge clk_sys);
        check("buffer full", 16'(rx_ready), 16'h0000);
        cur.rx_active = 1'b1;
        put();
        push(8'h96);
        rx_valid <= 1'b0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        check("rx status", 16'(last_cmd), 16'(enc(cur)));
        cur.rx_error = 1'b1;
        put();
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        check("rx error", 16'(last_cmd), 16'(enc(cur)));
        check("rx start", 16'(start_nxt), 16'h0001);
        check("rx count", rx_cnt, 16'h0003);
        check("rx 0", {8'h00, link_u.rx_log[0]}, 16'h003c);
        check("rx 1", {8'h00, link_u.rx_log[1]}, 16'h00c3);
        check("rx 2", {8'h00, link_u.rx_log[2]}, 16'h0096);
        cur.rx_active = 1'b0;
        cur.rx_error = 1'b0;
        put();
        wait_idle();
        cur.host_disc = 1'b1;
        cur.dp_se = 1'b1;
        one("host disconnect");
        check("turnaround", 16'(ta_err), 16'h0000);
        results();
    end
endmodule : ulpi_rx_status_command_gen_tb_top
